// [hw/vpsc_ctl.sv]
// Notes on behaviour
// R1 - selected port: clock term, detector, repeater on
// R2 - data terms and link only after clock valid
// R3 - unselected ports fully switched off
// R4 - no valid clock: data terms off, link hi-z
// R5 - mode pin high I2C, low GPIO
// R6 - control port is target only
// R7 - I2C mode: irq on status changes
// R8 - reading status register drops irq
// R9 - status shows power, port, clock detect
// R10 - I2C sets edge, offset, power, detect, port
// R11 - GPIO: port from two select lines
// R12 - GPIO: power state from low-power pin
// R13 - GPIO: fastest edge rate
// R14 - GPIO: offset from offset pin
// R15 - GPIO: irq mirrors selected clock valid
// R16 - detect bypass only in I2C mode
// R17 - controller keeps detect enabled normally
// R18 - four edge rates, fastest after reset
// R19 - hot-plug routing per port
// R20 - automatic port select only in I2C
// R21 - indicator follows selected port power
// R22 - select lines decode, first is upper
// R23 - low-power pin: everything high impedance; control target still answers, irq and indicator stay driven
// R24 - address from strap, two values
// R25 - standby via I2C keeps control, hot-plug
// R26 - all pin inputs synchronised first
// R27 - irq sticky until status read
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_map.svh"
module vpsc_ctl (
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire logic       I2C_MODE_SEL,
  input  wire logic       SOURCE_SELECT_LOW,
  input  wire logic       SOURCE_SELECT_HIGH,
  input  wire logic       POWER_DOWN_N,
  input  wire logic [3:0] SOURCE_POWER_SENSE,
  input  wire logic       SINK_HOTPLUG_IN,
  input  wire logic [3:0] CLOCK_VALID,
  input  wire logic       ADDR_STRAP,
  input  wire logic [1:0] OFFSET_PIN,
  input  wire logic       LOCAL_SCL,
  input  wire logic       LOCAL_SDA_IN,
  output logic            LOCAL_SDA_OUT,
  output logic            LOCAL_SDA_OE,
  output logic [3:0]      CLK_TERM_EN,
  output logic [3:0]      CLK_DETECT_EN,
  output logic [3:0]      DDC_REPEAT_EN,
  output logic [3:0]      RX_EN,
  output logic [3:0]      DATA_TERM_EN,
  output logic            LINK_OUT_EN,
  output logic [1:0]      EDGE_RATE,
  output logic [1:0]      OFFSET_SEL,
  output logic [3:0]      SOURCE_HOTPLUG_OUT,
  output logic            HOTPLUG_OE,
  output logic            SELECTED_POWER_INDICATOR,
  output logic            IRQ
);
  import vpsc_pkg::*;

  vpsc_state_type s_q, s_d;
  logic           i2c, sleep, stby, ok, evt, clr;
  logic [3:0]     oh;

  function automatic logic [7:0] rd_reg(input vpsc_state_type s, input logic [7:0] a,
                                        input logic okv);
    if (a == `VPSC_REG_STATUS) begin
      rd_reg = {s.pwr_b, s.port, okv, 1'b0}; // R9
    end else if (a == `VPSC_REG_CFG) begin
      rd_reg = s.cfg;
    end else if (a == `VPSC_REG_OFFS) begin
      rd_reg = {6'h00, s.offs};
    end else begin
      rd_reg = 8'h00;
    end
  endfunction

  // ********************************
  // control decisions
  // ********************************
  always_comb begin
    i2c  = s_q.mode_b; // R5
    sleep = !s_q.pd_b ||
           (i2c && s_q.cfg[`VPSC_CFG_PM+1:`VPSC_CFG_PM] == `VPSC_PM_LOWP); // R12 R23
    stby = i2c && s_q.cfg[`VPSC_CFG_PM+1:`VPSC_CFG_PM] == `VPSC_PM_STBY; // R25
    // bypass honoured only in I2C mode; GPIO keeps detection on
    ok   = s_q.cv_b[s_q.port] || (i2c && s_q.cfg[`VPSC_CFG_BYP]); // R16
    oh   = 4'h1 << s_q.port;
    evt  = i2c && (s_q.pwr_b != s_q.ppwr || s_q.port != s_q.pport
                   || ok != s_q.pcv); // R7
  end

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic rise, fall, start, stop;
    logic [7:0] nptr;
    s_d   = s_q;
    clr   = 1'b0;
    nptr  = s_q.ptr + 8'h01;
    rise  = s_q.scl_b && !s_q.scl_c;
    fall  = !s_q.scl_b && s_q.scl_c;
    start = s_q.scl_b && s_q.scl_c && s_q.sda_c && !s_q.sda_b;
    stop  = s_q.scl_b && s_q.scl_c && !s_q.sda_c && s_q.sda_b;
    // two-stage synchronisers on every pin input
    s_d.mode_a = I2C_MODE_SEL;       s_d.mode_b = s_q.mode_a; // R26
    s_d.sel_a = {SOURCE_SELECT_HIGH, SOURCE_SELECT_LOW};
    s_d.sel_b = s_q.sel_a;
    s_d.pd_a = POWER_DOWN_N;         s_d.pd_b = s_q.pd_a;
    s_d.pwr_a = SOURCE_POWER_SENSE;  s_d.pwr_b = s_q.pwr_a;
    s_d.hpd_a = SINK_HOTPLUG_IN;     s_d.hpd_b = s_q.hpd_a;
    s_d.cv_a = CLOCK_VALID;          s_d.cv_b = s_q.cv_a;
    s_d.adr_a = ADDR_STRAP;          s_d.adr_b = s_q.adr_a;
    s_d.ovs_a = OFFSET_PIN;          s_d.ovs_b = s_q.ovs_a;
    s_d.scl_a = LOCAL_SCL;           s_d.scl_b = s_q.scl_a;
    s_d.sda_a = LOCAL_SDA_IN;        s_d.sda_b = s_q.sda_a;
    s_d.scl_c = s_q.scl_b;           s_d.sda_c = s_q.sda_b;

    // port choice
    if (!i2c) begin
      s_d.port = s_q.sel_b; // R11 R22
    end else if (s_q.cfg[`VPSC_CFG_AUTO]) begin
      // lowest-numbered powered source wins; none powered keeps the manual port
      s_d.port = s_q.cfg[`VPSC_CFG_PORT+1:`VPSC_CFG_PORT]; // R20
      for (int i = 3; i >= 0; i--) begin
        if (s_q.pwr_b[i]) begin
          s_d.port = 2'(i);
        end
      end
    end else begin
      s_d.port = s_q.cfg[`VPSC_CFG_PORT+1:`VPSC_CFG_PORT]; // R10
    end

    // ********************************
    // local control target
    // ********************************
    // only SDA is ever driven, and only low; SCL is never an output
    if (!i2c || stop) begin // R6
      s_d.st = I_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (start) begin
      s_d.st = I_ADDR;
      s_d.cnt = 4'h0;
      s_d.gotp = 1'b0;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.st)
        I_ADDR, I_WRX: begin
          if (rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_b};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (fall && s_q.cnt == 4'h8) begin
            s_d.sda_oe = 1'b1;
            if (s_q.st == I_ADDR) begin
              if (s_q.sh[7:1] == {`VPSC_ADDR_BASE, s_q.adr_b}) begin // R24
                s_d.rd = s_q.sh[0];
                s_d.st = I_ACKA;
              end else begin
                s_d.sda_oe = 1'b0;
                s_d.st = I_IDLE;
              end
            end else begin
              s_d.st = I_ACKW;
              if (!s_q.gotp) begin
                s_d.ptr = s_q.sh;
                s_d.gotp = 1'b1;
              end else begin
                s_d.ptr = nptr;
                if (s_q.ptr == `VPSC_REG_CFG) begin
                  s_d.cfg = s_q.sh; // R10 R18
                end else if (s_q.ptr == `VPSC_REG_OFFS) begin
                  s_d.offs = s_q.sh[1:0];
                end
              end
            end
          end
        end
        I_ACKA: begin
          if (fall) begin
            s_d.cnt = 4'h0;
            s_d.sda_oe = 1'b0;
            s_d.st = I_WRX;
            if (s_q.rd) begin
              s_d.sh = rd_reg(s_q, s_q.ptr, ok);
              s_d.sda_oe = !s_d.sh[7];
              s_d.st = I_RDAT;
              clr = s_q.ptr == `VPSC_REG_STATUS; // R8
            end
          end
        end
        I_ACKW: begin
          if (fall) begin
            s_d.cnt = 4'h0;
            s_d.sda_oe = 1'b0;
            s_d.st = I_WRX;
          end
        end
        I_RDAT: begin
          if (rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (fall && s_q.cnt == 4'h8) begin
            s_d.sda_oe = 1'b0;
            s_d.st = I_RACK;
          end else if (fall) begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe = !s_q.sh[6];
          end
        end
        I_RACK: begin
          if (rise && s_q.sda_b) begin
            s_d.st = I_IDLE;
          end else if (fall) begin
            s_d.ptr = nptr;
            s_d.cnt = 4'h0;
            s_d.sh = rd_reg(s_q, nptr, ok);
            s_d.sda_oe = !s_d.sh[7];
            s_d.st = I_RDAT;
            clr = nptr == `VPSC_REG_STATUS; // R8
          end
        end
        default: s_d.st = I_IDLE;
      endcase
    end

    // ********************************
    // interrupt and outputs
    // ********************************
    s_d.ppwr = s_q.pwr_b;
    s_d.pport = s_q.port;
    s_d.pcv = ok;
    // a change seen in the clearing cycle still raises the request
    s_d.irq = i2c && ((s_q.irq && !clr) || evt); // R7 R27
    s_d.irq_out = i2c ? s_q.irq : ok; // R15

    s_d.ddc_en = sleep ? 4'h0 : oh; // R1 R3 R25
    s_d.clk_term = (sleep || stby) ? 4'h0 : oh; // R1 R3
    s_d.det_en = s_d.clk_term;
    s_d.rx_en = s_d.clk_term;
    s_d.link_en = !sleep && !stby && ok; // R2 R4
    s_d.data_term = s_d.link_en ? oh : 4'h0;
    s_d.hpd_oe = !sleep; // R23
    for (int i = 0; i < 4; i++) begin
      s_d.hpd[i] = (2'(i) == s_q.port) ? s_q.hpd_b : s_q.pwr_b[i]; // R19
    end
    s_d.ind = s_q.pwr_b[s_q.port]; // R21
    s_d.edge_r = i2c ? s_q.cfg[`VPSC_CFG_EDGE+1:`VPSC_CFG_EDGE] : `VPSC_EDGE_FAST; // R13
    s_d.offs_out = i2c ? s_q.offs : s_q.ovs_b; // R14
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s_q      <= '0;
      s_q.cfg  <= `VPSC_CFG_RST; // R18
      s_q.offs <= `VPSC_OFFS_RST;
      // bus sync flops start at the idle level, so no false edge follows reset
      s_q.scl_a <= `VPSC_BUS_IDLE;
      s_q.scl_b <= `VPSC_BUS_IDLE;
      s_q.scl_c <= `VPSC_BUS_IDLE;
      s_q.sda_a <= `VPSC_BUS_IDLE;
      s_q.sda_b <= `VPSC_BUS_IDLE;
      s_q.sda_c <= `VPSC_BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign LOCAL_SDA_OUT = 1'b0;
  assign LOCAL_SDA_OE = s_q.sda_oe;
  assign CLK_TERM_EN = s_q.clk_term;
  assign CLK_DETECT_EN = s_q.det_en;
  assign DDC_REPEAT_EN = s_q.ddc_en;
  assign RX_EN = s_q.rx_en;
  assign DATA_TERM_EN = s_q.data_term;
  assign LINK_OUT_EN = s_q.link_en;
  assign EDGE_RATE = s_q.edge_r;
  assign OFFSET_SEL = s_q.offs_out;
  assign SOURCE_HOTPLUG_OUT = s_q.hpd;
  assign HOTPLUG_OE = s_q.hpd_oe;
  assign SELECTED_POWER_INDICATOR = s_q.ind;
  assign IRQ = s_q.irq_out;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_unsel_off: assert property (
    ((CLK_TERM_EN | RX_EN | DDC_REPEAT_EN) & ~$past(oh)) == 4'h0) // R3
    else $error("unselected port enabled");
  a_sel_on: assert property (!sleep && !stby |=> CLK_TERM_EN == $past(oh)
    && CLK_DETECT_EN == $past(oh) && DDC_REPEAT_EN == $past(oh)) // R1
    else $error("selected port not enabled");
  a_data_needs_clk: assert property (|DATA_TERM_EN |-> $past(ok)) // R2
    else $error("data terminations without clock");
  a_link_hiz: assert property (!ok |=> !LINK_OUT_EN && DATA_TERM_EN == 4'h0) // R4
    else $error("link driven without clock");
  a_sleep_hiz: assert property (!s_q.pd_b |=> !HOTPLUG_OE && !LINK_OUT_EN) // R23
    else $error("outputs active in low power");
  a_irq_raise: assert property (evt ##1 s_q.mode_b |=> IRQ) // R7
    else $error("missed interrupt");
  a_irq_sticky: assert property (s_q.irq && !clr && s_q.mode_b |=> s_q.irq) // R27
    else $error("interrupt dropped before read");
  a_read_clears: assert property (clr && !evt |=> !s_q.irq) // R8
    else $error("status read did not clear");
  a_gpio_irq: assert property (!s_q.mode_b |=> IRQ == $past(ok)) // R15
    else $error("gpio irq not clock valid");
  a_gpio_edge: assert property (!s_q.mode_b |=> EDGE_RATE == `VPSC_EDGE_FAST) // R13
    else $error("gpio edge not fastest");

  c_link_up: cover property (!LINK_OUT_EN ##1 LINK_OUT_EN);
  c_status_read: cover property (clr);
  c_irq_event: cover property (evt ##2 IRQ);
  c_gpio_irq: cover property (!s_q.mode_b && IRQ);
endmodule
`default_nettype wire

// [hw/vpsc_map.svh]
`ifndef VPSC_MAP_SVH
`define VPSC_MAP_SVH
// register offsets on the local control bus
`define VPSC_REG_STATUS 8'h01
`define VPSC_REG_CFG    8'h02
`define VPSC_REG_OFFS   8'h03
// config register fields
`define VPSC_CFG_PM     6
`define VPSC_CFG_BYP    5
`define VPSC_CFG_AUTO   4
`define VPSC_CFG_PORT   2
`define VPSC_CFG_EDGE   0
// status register fields
`define VPSC_ST_PWR     4
`define VPSC_ST_PORT    2
`define VPSC_ST_CLK     1
// reset values and codes
`define VPSC_CFG_RST    8'h00
`define VPSC_OFFS_RST   2'h0
`define VPSC_EDGE_FAST  2'h0
`define VPSC_PM_STBY    2'h1
`define VPSC_PM_LOWP    2'h2
`define VPSC_ADDR_BASE  6'h16
`define VPSC_BUS_IDLE   1'b1
`endif

// [hw/vpsc_pkg.sv]
package vpsc_pkg;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACKA, I_WRX, I_ACKW, I_RDAT, I_RACK
  } vpsc_i2c_type;
  typedef struct packed {
    logic mode_a, mode_b, pd_a, pd_b, hpd_a, hpd_b;
    logic [1:0] sel_a, sel_b, ovs_a, ovs_b;
    logic [3:0] pwr_a, pwr_b, cv_a, cv_b;
    logic scl_a, scl_b, scl_c, sda_a, sda_b, sda_c, adr_a, adr_b;
    logic [7:0] cfg;
    logic [1:0] offs, port, pport;
    logic [3:0] ppwr;
    logic pcv, irq;
    vpsc_i2c_type st;
    logic [3:0] cnt;
    logic [7:0] sh, ptr;
    logic rd, gotp, sda_oe;
    logic [3:0] clk_term, det_en, ddc_en, rx_en, data_term, hpd;
    logic link_en, hpd_oe, ind, irq_out;
    logic [1:0] edge_r, offs_out;
  } vpsc_state_type;
endpackage

// [dv/vpsc_i2c_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// controller on the local control bus
// ****************************************
module vpsc_i2c_ctrl (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hp;
    repeat (16) @(posedge clk);
  endtask
  task automatic start;
    sda_pull <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_pull <= 1'b1;
    hp;
    scl <= 1'b0;
  endtask
  task automatic stop;
    hp;
    sda_pull <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_pull <= 1'b0;
    hp;
  endtask
  // ninth bit: b9 is our own ack level, r9 the level seen on the wire
  task automatic xfer(input logic [7:0] w, input logic b9, output logic [7:0] r,
                      output logic r9);
    logic [8:0] v;
    logic [8:0] got;
    v = {w, b9};
    for (int i = 8; i >= 0; i--) begin
      hp;
      sda_pull <= ~v[i];
      hp;
      scl <= 1'b1;
      hp;
      got[i] = sda;
      scl <= 1'b0;
    end
    {r, r9} = got;
  endtask
  // wd is written as given; detect bypass is set only when the caller's data sets it
  task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
    logic [7:0] r;
    logic [3:0] k;
    start;
    xfer({a, 1'b0}, 1'b1, r, k[0]);
    xfer(p, 1'b1, r, k[1]);
    if (rd) begin
      start;
      xfer({a, 1'b1}, 1'b1, r, k[2]);
      xfer(8'hff, 1'b1, rdat, k[3]);
    end else begin
      xfer(wd, 1'b1, r, k[2]);
    end
    stop;
    ok = ~|k[2:0];
  endtask
endmodule
`default_nettype wire

// [dv/tb_video_port_switch_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_map.svh"
module tb_video_port_switch_control;
  logic        clk, rst, mode, s_lo, s_hi, pdn, sink, strap, ok;
  logic [3:0]  pwr, cv, cterm, cdet, ddc, rx, dterm, hpd;
  logic [1:0]  opin, edg, offs;
  logic        sda_out, sda_oe, link, hp_oe, ind, irq;
  logic [7:0]  rv;
  logic [31:0] rng;
  int          n_mismatch, n_compared;
  wire logic   scl, pull, sda_w;
  // open drain with pull-up: low if either side pulls
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~pull;
  vpsc_ctl dut_u (.CLK_SYS(clk), .RESET(rst), .I2C_MODE_SEL(mode), .SOURCE_SELECT_LOW(s_lo),
    .SOURCE_SELECT_HIGH(s_hi), .POWER_DOWN_N(pdn), .SOURCE_POWER_SENSE(pwr),
    .SINK_HOTPLUG_IN(sink), .CLOCK_VALID(cv), .ADDR_STRAP(strap), .OFFSET_PIN(opin),
    .LOCAL_SCL(scl), .LOCAL_SDA_IN(sda_w), .LOCAL_SDA_OUT(sda_out), .LOCAL_SDA_OE(sda_oe),
    .CLK_TERM_EN(cterm), .CLK_DETECT_EN(cdet), .DDC_REPEAT_EN(ddc), .RX_EN(rx),
    .DATA_TERM_EN(dterm), .LINK_OUT_EN(link), .EDGE_RATE(edg), .OFFSET_SEL(offs),
    .SOURCE_HOTPLUG_OUT(hpd), .HOTPLUG_OE(hp_oe), .SELECTED_POWER_INDICATOR(ind), .IRQ(irq));
  vpsc_i2c_ctrl ctl_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(pull));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] exp_hpd(input logic [1:0] p);
    logic [3:0] r;
    r = pwr;
    r[p] = sink;
    return 8'(r);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic chk_port(input logic [1:0] p);
    chk(8'(cterm), 8'h1 << p);
    chk(8'(cdet), 8'h1 << p);
    chk(8'(ddc), 8'h1 << p);
    chk(8'(rx & ~(4'h1 << p)), 8'h0);
    chk(8'(rx), 8'h1 << p);
    chk(8'(dterm), cv[p] ? 8'h1 << p : 8'h0);
    chk(8'(link), 8'(cv[p]));
    chk(8'(hpd), exp_hpd(p));
    chk(8'({ind, hp_oe}), 8'({pwr[p], 1'b1}));
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    ctl_u.acc(1'b0, 7'h2d, a, d, rv, ok);
    settle;
  endtask
  initial begin
    rng = 32'h1bae2612;
    {rst, mode, s_lo, s_hi, pdn, sink, strap} = 7'b1000111;
    {pwr, cv, opin} = 10'h0;
    repeat (5) @(posedge clk);
    chk(8'({link, irq, hp_oe, sda_oe, edg}), 8'h0);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      {s_hi, s_lo} <= i[1:0];
      {sink, pwr} <= rng[4:0];
      opin <= 2'(rng[6:5] % 3);
      cv <= i[2] ? rng[11:8] | (4'h1 << i[1:0]) : rng[11:8] & ~(4'h1 << i[1:0]);
      settle;
      chk_port(i[1:0]);
      chk(8'(irq), 8'(cv[i[1:0]]));
      chk(8'({edg, offs}), 8'({2'h0, opin}));
    end
    pdn <= 1'b0;
    settle;
    chk(8'({cterm, ddc} | {dterm, rx}), 8'h0);
    chk(8'({link, hp_oe}), 8'h0);
    {pdn, mode, cv} <= 6'b110000;
    settle;
    cfg(`VPSC_REG_CFG, 8'h03);
    chk(8'({ok, edg}), 8'h07);
    strap <= 1'b0;
    settle;
    cfg(`VPSC_REG_CFG, 8'h00);
    chk(8'({ok, edg}), 8'h03);
    ctl_u.acc(1'b0, 7'h2c, `VPSC_REG_CFG, 8'h00, rv, ok);
    settle;
    chk(8'({ok, edg}), 8'h04);
    strap <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      rng = xs(rng);
      {cv, pwr} <= rng[7:0];
      settle;
      cfg(`VPSC_REG_CFG, 8'({p[1:0], p[1:0]}));
      chk_port(p[1:0]);
      chk(8'({ok, edg}), 8'({1'b1, p[1:0]}));
      ctl_u.acc(1'b1, 7'h2d, `VPSC_REG_STATUS, 8'h0, rv, ok);
      chk(rv, {pwr, p[1:0], cv[p], 1'b0});
      settle;
      chk(8'(irq), 8'h0);
    end
    pwr <= ~pwr;
    settle;
    pwr <= ~pwr;
    settle;
    chk(8'(irq), 8'h1);
    ctl_u.acc(1'b1, 7'h2d, `VPSC_REG_STATUS, 8'h0, rv, ok);
    settle;
    chk(8'(irq), 8'h0);
    cfg(`VPSC_REG_OFFS, 8'h02);
    chk(8'(offs), 8'h2);
    cfg(`VPSC_REG_CFG, 8'h80);
    chk(8'({cterm, ddc} | {dterm, rx}), 8'h00);
    chk(8'({link, hp_oe}), 8'h00);
    {cv, pwr} <= 8'hf4;
    cfg(`VPSC_REG_CFG, 8'h44);
    chk(8'({ddc, hp_oe}), 8'h05);
    chk(8'({link, dterm}), 8'h00);
    chk(8'({cterm, rx}), 8'h00);
    chk(8'(hpd), exp_hpd(2'h1));
    cv <= 4'h0;
    cfg(`VPSC_REG_CFG, 8'h30);
    chk(8'({cterm, link}), 8'h9);
    {mode, s_hi, s_lo} <= 3'b000;
    settle;
    chk(8'({cterm, link}), 8'h2);
    close_out;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
